// ---- common/edge_timing_pkg.sv ----
// package: register map, field layout and source codes of the edge timing control block
package edge_timing_pkg;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ctrl_ofs   = 8'h00;
    localparam logic [7:0] status_ofs = 8'h04;
    localparam logic [7:0] mask_ofs   = 8'h08;

    // control field positions
    localparam int first_stat_pos = 24;
    localparam int second_mode_pos = 23;
    localparam int second_pol_pos = 22;
    localparam int second_sel_lsb = 18;
    localparam int module_on_pos = 15;
    localparam int idle_stop_pos = 13;
    localparam int time_gen_pos = 12;
    localparam int edge_gate_pos = 11;
    localparam int discharge_pos = 10;

    // writable bits of the control register; all others read zero
    localparam logic [31:0] ctrl_wmask  = 32'h01ffbc00;
    localparam logic [31:0] ctrl_reset  = 32'h00000000;

    // interrupt status bit positions
    localparam int irq_first_pos  = 0;
    localparam int irq_second_pos = 1;
    localparam logic [1:0] irq_reset = 2'h0;

    // second-edge source codes
    localparam logic [3:0] sel_comp_two = 4'he;
    localparam logic [3:0] sel_reserved = 4'hf;
    localparam int num_sources = 15;

    // decoded control fields
    typedef struct packed {
        logic       first_stat;
        logic       second_mode;
        logic       second_pol;
        logic [3:0] second_sel;
        logic       module_on;
        logic       idle_stop;
        logic       time_gen;
        logic       edge_gate;
        logic       discharge;
    } ctrl_fields_t;

    // register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

endpackage : edge_timing_pkg

// ---- verilog/edge_timing_control.sv ----
// edge timing control: control register, edge selection, detection and interrupt
//
// Functional notes
// - first-edge flag set by edge, software writable
// - mode bit selects edge or level sensing
// - polarity bit selects rising or falling response
// - four-bit field picks second-edge source
// - module runs only while enable set
// - stop-in-idle halts module during idle
// - delay generation only while enable set
// - edge gate blocks all edges when clear
// - unimplemented bits ignore writes, read zero
`timescale 1ns/100ps
module edge_timing_control
    import edge_timing_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire bus_req_t    bus_req,
    output logic [31:0]      rdata_q,
    // system state
    input  wire logic        idle_mode,
    // first-edge qualified event from the first-edge selector
    input  wire logic        first_edge_event,
    // second-edge sources
    input  wire logic        timer_event,
    input  wire logic        compare_event,
    input  wire logic [6:0]  edge_pins,
    input  wire logic [2:0]  capture_events,
    input  wire logic        periph_clk_level,
    input  wire logic        comparator_one_output,
    input  wire logic        comparator_two_output,
    // block outputs
    output logic             module_active_q,
    output logic             second_edge_q,
    output logic             delay_gen_q,
    output logic             discharge_sink_q,
    output logic             irq_q
);

    logic [31:0]  ctrl_q;
    ctrl_fields_t f;
    logic [1:0]   irq_stat_q;
    logic [1:0]   irq_mask_q;
    logic [num_sources-1:0] src_raw;
    logic [num_sources-1:0] sync1_q;
    logic [num_sources-1:0] sync2_q;
    logic         sel_q;
    logic         sel_prev_q;
    logic         running;
    logic         gate_open;
    logic         active_lvl;
    logic         edge_hit;
    logic         second_evt;
    logic         first_evt;
    logic         wr_ctrl;

    // field view of the control register
    assign f.first_stat  = ctrl_q[first_stat_pos];
    assign f.second_mode = ctrl_q[second_mode_pos];
    assign f.second_pol  = ctrl_q[second_pol_pos];
    assign f.second_sel  = ctrl_q[second_sel_lsb +: 4];
    assign f.module_on   = ctrl_q[module_on_pos];
    assign f.idle_stop   = ctrl_q[idle_stop_pos];
    assign f.time_gen    = ctrl_q[time_gen_pos];
    assign f.edge_gate   = ctrl_q[edge_gate_pos];
    assign f.discharge   = ctrl_q[discharge_pos];

    assign wr_ctrl = bus_req.wr && (bus_req.addr == ctrl_ofs);

    // module runs while enabled and not halted by idle
    assign running   = f.module_on && !(f.idle_stop && idle_mode);
    assign gate_open = running && f.edge_gate;

    // source vector, index equals select code
    assign src_raw = {comparator_two_output, comparator_one_output, periph_clk_level,
                      capture_events, edge_pins[6:2], edge_pins[0], edge_pins[1],
                      compare_event, timer_event};

    // two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= src_raw;
            sync2_q <= sync1_q;
        end
    end

    // selected source, reserved code reads as a quiet low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_q      <= 1'b0;
            sel_prev_q <= 1'b0;
        end else begin
            sel_q      <= (f.second_sel == sel_reserved) ? 1'b0 : sync2_q[f.second_sel];
            sel_prev_q <= sel_q;
        end
    end

    // polarity maps the level, mode picks transition or level
    assign active_lvl = f.second_pol ? sel_q : !sel_q;
    assign edge_hit   = f.second_pol ? (sel_q && !sel_prev_q)
                                     : (!sel_q && sel_prev_q);
    assign second_evt = gate_open && (f.second_mode ? edge_hit : active_lvl);
    assign first_evt  = gate_open && first_edge_event;

    // control register; a hardware edge wins over a software clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= ctrl_reset;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus_req.wdata & ctrl_wmask;
            end
            if (first_evt) begin
                ctrl_q[first_stat_pos] <= 1'b1;
            end
        end
    end

    // block outputs, all registered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            module_active_q  <= 1'b0;
            second_edge_q    <= 1'b0;
            delay_gen_q      <= 1'b0;
            discharge_sink_q <= 1'b0;
        end else begin
            module_active_q  <= running;
            second_edge_q    <= second_evt;
            // delay generation expects comparator two as source; software sets it
            delay_gen_q      <= running && f.time_gen;
            discharge_sink_q <= f.discharge;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_q <= irq_reset;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (bus_req.wr && bus_req.addr == status_ofs && bus_req.wdata[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
            if (first_evt) begin
                irq_stat_q[irq_first_pos] <= 1'b1;
            end
            if (second_evt) begin
                irq_stat_q[irq_second_pos] <= 1'b1;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_q <= irq_reset;
        end else if (bus_req.wr && bus_req.addr == mask_ofs) begin
            irq_mask_q <= bus_req.wdata[1:0];
        end
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h00000000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                ctrl_ofs:   rdata_q <= ctrl_q & ctrl_wmask;
                status_ofs: rdata_q <= {30'h0, irq_stat_q};
                mask_ofs:   rdata_q <= {30'h0, irq_mask_q};
                default:    rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    // unimplemented control bits stay zero in the register at all times
    unimpl_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (ctrl_q & ~ctrl_wmask) == 32'h0) else $error("unimplemented bits set");

    // gate closed means no second-edge output
    gate_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
        !gate_open |=> !second_edge_q) else $error("edge passed closed gate");

    // disabled module gives no delay generation
    delay_off_a: assert property (@(posedge clk) disable iff (!nrst)
        !f.module_on |=> !delay_gen_q) else $error("delay active while off");

    // idle halt
    idle_halt_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.idle_stop && idle_mode) |=> !module_active_q) else $error("ran in idle");

    // enable follows bit
    module_on_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.module_on && !idle_mode) |=> module_active_q) else $error("not running");

    // first edge sets the flag
    first_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        first_evt |=> f.first_stat) else $error("first flag not set");

    // rising edge mode: event only after low then high
    rise_edge_a: assert property (@(posedge clk) disable iff (!nrst)
        (gate_open && f.second_mode && f.second_pol && sel_q && !sel_prev_q)
        |=> second_edge_q) else $error("rising edge missed");

    // level mode falling: low level gives event
    level_low_a: assert property (@(posedge clk) disable iff (!nrst)
        (gate_open && !f.second_mode && !f.second_pol && !sel_q)
        |=> second_edge_q) else $error("low level missed");

    // reserved code never selects anything
    reserved_sel_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.second_sel == sel_reserved) |=> !sel_q) else $error("reserved source live");

    // second synchroniser stage copies the first, one cycle late
    sync_pipe_a: assert property (@(posedge clk) disable iff (!nrst)
        sync2_q == $past(sync1_q)) else $error("synchroniser skipped a stage");

    // previous sample register trails the selected level by one cycle
    sel_prev_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_prev_q == $past(sel_q)) else $error("previous sample out of step");

    // a closed gate never lets a first edge raise the flag
    gate_first_a: assert property (@(posedge clk) disable iff (!nrst)
        (!gate_open && !wr_ctrl && !f.first_stat) |=> !f.first_stat)
        else $error("first edge passed closed gate");

    // level mode, rising polarity: high level gives the event
    level_high_a: assert property (@(posedge clk) disable iff (!nrst)
        (gate_open && !f.second_mode && f.second_pol && sel_q) |=> second_edge_q)
        else $error("high level missed");

    // level mode, rising polarity: low level stays quiet
    level_off_a: assert property (@(posedge clk) disable iff (!nrst)
        (gate_open && !f.second_mode && f.second_pol && !sel_q) |=> !second_edge_q)
        else $error("low level fired on rising polarity");

    // edge mode, falling polarity: high then low gives the event
    fall_edge_a: assert property (@(posedge clk) disable iff (!nrst)
        (gate_open && f.second_mode && !f.second_pol && !sel_q && sel_prev_q)
        |=> second_edge_q) else $error("falling edge missed");

    // edge mode, rising polarity: anything but a rise stays quiet
    rise_block_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.second_mode && f.second_pol && !(sel_q && !sel_prev_q)) |=> !second_edge_q)
        else $error("edge event without a rise");

    // edge mode with steady settings yields single-cycle pulses only
    edge_single_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.second_mode && second_edge_q && $stable(ctrl_q)) |=> !second_edge_q)
        else $error("edge pulse longer than a cycle");

    // clearing the enable stops the module
    mod_off_a: assert property (@(posedge clk) disable iff (!nrst)
        !f.module_on |=> !module_active_q) else $error("module ran while off");

    // without stop-in-idle the module keeps running through idle
    idle_run_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.module_on && !f.idle_stop) |=> module_active_q)
        else $error("module halted without stop-in-idle");

    // running with the time-generation bit gives delay generation
    delay_on_a: assert property (@(posedge clk) disable iff (!nrst)
        (running && f.time_gen) |=> delay_gen_q) else $error("delay generation missing");

    // time-generation bit clear means no delay generation
    time_generation_enable_off_a: assert property (@(posedge clk) disable iff (!nrst)
        !f.time_gen |=> !delay_gen_q) else $error("delay without enable bit");

    // an idle halt also stops delay generation
    delay_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.idle_stop && idle_mode) |=> !delay_gen_q) else $error("delay ran in idle");

    // discharge sink follows its control bit one cycle later
    discharge_copy_a: assert property (@(posedge clk) disable iff (!nrst)
        discharge_sink_q == $past(f.discharge)) else $error("discharge sink out of step");

    // a qualified first edge raises its status bit
    first_status_a: assert property (@(posedge clk) disable iff (!nrst)
        first_evt |=> irq_stat_q[irq_first_pos]) else $error("first status not set");

    // a qualified second edge raises its status bit
    second_status_a: assert property (@(posedge clk) disable iff (!nrst)
        second_evt |=> irq_stat_q[irq_second_pos]) else $error("second status not set");

    // sticky status holds until software clears it
    stat_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (irq_stat_q[irq_first_pos] && !(bus_req.wr && bus_req.addr == status_ofs))
        |=> irq_stat_q[irq_first_pos]) else $error("status bit dropped");

    // writing one clears the status bit when no event competes
    stat_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (bus_req.wr && bus_req.addr == status_ofs && bus_req.wdata[irq_first_pos]
         && !first_evt) |=> !irq_stat_q[irq_first_pos]) else $error("status not cleared");

    // first-edge flag holds unless software rewrites the control word
    flag_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (f.first_stat && !wr_ctrl) |=> f.first_stat) else $error("first flag dropped");

    // a control write without a competing edge lands as written, masked
    sw_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ctrl && !first_evt) |=> ctrl_q == $past(bus_req.wdata & ctrl_wmask))
        else $error("control write lost");

    // mask register takes its two bits from a mask write
    mask_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (bus_req.wr && bus_req.addr == mask_ofs) |=> irq_mask_q == $past(bus_req.wdata[1:0]))
        else $error("mask write lost");

    // interrupt is the registered or of unmasked status
    irq_level_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_q == $past(|(irq_stat_q & irq_mask_q))) else $error("interrupt level wrong");

    // read data stand only after a read strobe
    rd_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        !bus_req.rd |=> rdata_q == 32'h00000000) else $error("read data without strobe");

    // control reads never show unimplemented bits
    rd_ctrl_a: assert property (@(posedge clk) disable iff (!nrst)
        (bus_req.rd && bus_req.addr == ctrl_ofs) |=> (rdata_q & ~ctrl_wmask) == 32'h0)
        else $error("unimplemented bits read back");

    // status reads return the sticky bits in the low positions
    rd_status_a: assert property (@(posedge clk) disable iff (!nrst)
        (bus_req.rd && bus_req.addr == status_ofs) |=> rdata_q == {30'h0, $past(irq_stat_q)})
        else $error("status read wrong");

    // unmapped addresses read as zero
    rd_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
        (bus_req.rd && bus_req.addr != ctrl_ofs && bus_req.addr != status_ofs
         && bus_req.addr != mask_ofs) |=> rdata_q == 32'h00000000)
        else $error("unmapped read not zero");

endmodule : edge_timing_control

// ---- verification/source_model.sv ----
// far-side model: event lines and edge pins feeding the second-edge selector
`timescale 1ns/100ps
module source_model (
    // source levels, indexed by selector code
    input  wire logic [14:0] src,
    // lines into the block
    output logic             timer_event,
    output logic             compare_event,
    output logic [6:0]       edge_pins,
    output logic [2:0]       capture_events,
    output logic             periph_clk_level,
    output logic             comparator_one_output,
    output logic             comparator_two_output
);
    // the two lowest pins sit in swapped order against their codes
    assign timer_event           = src[0];
    assign compare_event         = src[1];
    assign edge_pins             = {src[8:4], src[2], src[3]};
    assign capture_events        = src[11:9];
    assign periph_clk_level      = src[12];
    assign comparator_one_output = src[13];
    assign comparator_two_output = src[14];
endmodule : source_model

// ---- verification/tb.sv ----
// testbench: registers, run control, second-edge selection and interrupt
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected t=%0t got %h want %h", $time, a, b); end end
module tb;
    import edge_timing_pkg::*;
    logic        clk, nrst, idle_mode, first_edge_event;
    bus_req_t    req;
    logic [14:0] src;
    logic [31:0] rdata_q, d, w;
    logic        timer_event, compare_event, periph_clk_level;
    logic [6:0]  edge_pins;
    logic [2:0]  capture_events;
    logic        comparator_one_output, comparator_two_output;
    logic        module_active_q, second_edge_q, delay_gen_q, discharge_sink_q, irq_q;
    int          n_fail, compares, n;
    logic [3:0]  s;

    source_model source_model_inst (.src(src), .timer_event(timer_event),
        .compare_event(compare_event), .edge_pins(edge_pins),
        .capture_events(capture_events), .periph_clk_level(periph_clk_level),
        .comparator_one_output(comparator_one_output),
        .comparator_two_output(comparator_two_output));
    edge_timing_control edge_timing_control_inst (.clk(clk), .nrst(nrst), .bus_req(req),
        .rdata_q(rdata_q), .idle_mode(idle_mode), .first_edge_event(first_edge_event),
        .timer_event(timer_event), .compare_event(compare_event), .edge_pins(edge_pins),
        .capture_events(capture_events), .periph_clk_level(periph_clk_level),
        .comparator_one_output(comparator_one_output),
        .comparator_two_output(comparator_two_output), .module_active_q(module_active_q),
        .second_edge_q(second_edge_q), .delay_gen_q(delay_gen_q),
        .discharge_sink_q(discharge_sink_q), .irq_q(irq_q));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // control word from mode, polarity and source fields
    function automatic logic [31:0] sc(input logic [3:0] sel, input logic m, input logic p);
        return (32'(m) << second_mode_pos) | (32'(p) << second_pol_pos) |
               (32'(sel) << second_sel_lsb);
    endfunction : sc

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        req.addr  <= a;
        req.wdata <= v;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr    <= 1'b0;
        // let an edge pass so back-to-back calls never assign the strobe twice at once
        @(posedge clk);
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd   <= 1'b0;
        #1 v = rdata_q;
        @(posedge clk);
    endtask : rd

    // count second-edge pulses over a window longer than the latency
    task automatic pulses(output int c);
        c = 0;
        repeat (10) begin
            @(posedge clk);
            #1 if (second_edge_q === 1'b1) c++;
        end
    endtask : pulses

    task automatic summarize;
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial begin
        nrst = 1'b0; req = '0; idle_mode = 1'b0; first_edge_event = 1'b0; src = '0;
        n_fail = 0; compares = 0;
        w = $urandom(32'h5c04e87e);
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 4; a++) begin
            rd(8'(a * 4), d);
            `CHK(d, 32'h0)
        end
        repeat (4) begin
            w = $urandom;
            wr(ctrl_ofs, w);
            rd(ctrl_ofs, d);
            `CHK(d, w & ctrl_wmask)
        end
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, d);
        `CHK(d, 32'h0)
        // run enable, stop in idle, delay generation and discharge sink
        for (int i = 0; i < 16; i++) begin
            wr(ctrl_ofs, (i[0] ? 32'h8000 : 0) | (i[2] ? 32'h2000 : 0) |
               (i[3] ? 32'h1400 : 0) | sc(sel_comp_two, 0, 0));
            idle_mode <= i[1];
            repeat (3) @(posedge clk);
            `CHK(module_active_q, i[0] & !(i[2] & i[1]))
            `CHK(delay_gen_q, i[0] & !(i[2] & i[1]) & i[3])
            `CHK(discharge_sink_q, i[3])
        end
        idle_mode <= 1'b0;
        // level mode: only the selected source reaches the output
        for (int k = 0; k < 16; k++) begin
            wr(ctrl_ofs, 32'h8800 | sc(4'(k), 0, 1));
            src <= ~(15'(1) << k);
            repeat (6) @(posedge clk);
            `CHK(second_edge_q, 1'b0)
            src <= 15'(1) << k;
            repeat (6) @(posedge clk);
            `CHK(second_edge_q, 1'b0 ^ (k != 15))
        end
        // edge mode, both polarities, gate open and closed
        for (int i = 0; i < 4; i++) begin
            s = 4'($urandom_range(0, 14));
            src <= '0;
            wr(ctrl_ofs, (i[1] ? 32'h8800 : 32'h8000) | sc(s, 1, i[0]));
            repeat (6) @(posedge clk);
            src <= 15'(1) << s;
            pulses(n);
            `CHK(n, int'(i[1] & i[0]))
            src <= '0;
            pulses(n);
            `CHK(n, int'(i[1] & !i[0]))
        end
        // first edge sets the flag and the interrupt
        wr(status_ofs, 32'h3);
        wr(mask_ofs, 32'h1);
        wr(ctrl_ofs, 32'h8800);
        first_edge_event <= 1'b1;
        @(posedge clk);
        first_edge_event <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(irq_q, 1'b1)
        rd(ctrl_ofs, d);
        `CHK(d[first_stat_pos], 1'b1)
        rd(status_ofs, d);
        `CHK(d[irq_second_pos], 1'b1)
        wr(mask_ofs, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq_q, 1'b0)
        wr(mask_ofs, 32'h1);
        wr(status_ofs, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq_q, 1'b0)
        wr(ctrl_ofs, 32'h8000);
        rd(ctrl_ofs, d);
        `CHK(d[first_stat_pos], 1'b0)
        first_edge_event <= 1'b1;
        @(posedge clk);
        first_edge_event <= 1'b0;
        repeat (2) @(posedge clk);
        rd(ctrl_ofs, d);
        `CHK(d[first_stat_pos], 1'b0)
        summarize();
    end
endmodule : tb
